// ### rtl/dbc_codec.sv
// Balanced byte link encoder, serialiser, clock recovery and deserialiser.
`timescale 1ns/10ps
`default_nettype none
module dbc_codec (
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // Host transmit side.
  input  wire logic [7:0]         tx_byte_i,
  input  wire logic               tx_dc_i,
  input  wire logic               tx_load_ack_n_i,
  output logic                    tx_word_ready_o,
  // Radio baseband side.
  output logic                    tx_serial_o,
  input  wire logic               rx_serial_i,
  // Host receive side.
  output logic                    rx_word_ready_o,
  input  wire logic               rx_take_ack_n_i,
  output dbc_pkg::dbc_word_t      rx_word_o
);
  import dbc_pkg::*;

  // ****************************************
  // Disparity and encoding.
  // ****************************************
  function automatic logic signed [5:0] disparity(input logic [7:0] b);
    logic signed [5:0] d;
    d = -6'sd8;
    for (int i = 0; i < 8; i++) begin
      d = d + (b[i] ? 6'sd2 : 6'sd0);
    end
    return d;
  endfunction

  dbc_state_t st_r;
  dbc_state_t st_nxt;
  logic       tx_load;
  logic       rx_sample;
  logic       rx_bit;
  logic       rx_done;
  logic       rx_align;
  logic [7:0] enc_byte;
  logic       enc_dc;
  logic       enc_inv;
  logic signed [5:0] enc_disp;

  always_comb begin
    st_nxt    = st_r;
    tx_load   = (st_r.tx_cyc == BIT_LAST) && (st_r.tx_idx == WORD_LAST);
    // With nothing loaded the shifter falls back to the idle control word.
    enc_byte  = st_r.hold_valid ? st_r.hold_byte : IDLE_BYTE;
    enc_dc    = st_r.hold_valid ? st_r.hold_dc : DC_CTRL;
    enc_disp  = disparity(enc_byte);
    enc_inv   = (enc_disp < 0) == (st_r.run_sum < 0);

    // Transmit: host loads the holding word while it is empty.
    if (!st_r.hold_valid && !tx_load_ack_n_i) begin
      st_nxt.hold_valid = 1'b1;
      st_nxt.hold_byte  = tx_byte_i;
      st_nxt.hold_dc    = tx_dc_i;
    end
    if (st_r.tx_cyc == BIT_LAST) begin
      st_nxt.tx_cyc = 8'h0000;
      if (tx_load) begin
        st_nxt.tx_idx           = 4'h0000;
        st_nxt.tx_shift.inv_bar = ~enc_inv;
        st_nxt.tx_shift.inv     = enc_inv;
        st_nxt.tx_shift.payload = enc_byte ^ {8{enc_inv}};
        st_nxt.tx_shift.dc      = enc_dc ^ enc_inv;
        st_nxt.tx_shift.dc_bar  = ~(enc_dc ^ enc_inv);
        st_nxt.run_sum = enc_inv ? st_r.run_sum - enc_disp
                                 : st_r.run_sum + enc_disp;
        // A strobe taken in this same cycle is kept for the next word.
        if (st_r.hold_valid) begin
          st_nxt.hold_valid = 1'b0;
        end
      end else begin
        st_nxt.tx_idx   = st_r.tx_idx + 4'h0001;
        st_nxt.tx_shift = dbc_word_t'({st_r.tx_shift[10:0], 1'b0});
      end
    end else begin
      st_nxt.tx_cyc = st_r.tx_cyc + 8'h0001;
    end

    // Receive: three-sample agreement filter, edge-locked phase, mid-bit sampling.
    st_nxt.filt = {st_r.filt[1:0], rx_serial_i};
    if (st_r.filt == 3'h7) begin
      st_nxt.rx_lvl = 1'b1;
    end else if (st_r.filt == 3'h0) begin
      st_nxt.rx_lvl = 1'b0;
    end
    rx_sample = (st_r.rx_cyc == BIT_MID);
    rx_bit    = st_r.rx_lvl;
    rx_done   = 1'b0;
    rx_align  = 1'b0;
    if (st_nxt.rx_lvl != st_r.rx_lvl || st_r.rx_cyc == BIT_LAST) begin
      st_nxt.rx_cyc = 8'h0000;
    end else begin
      st_nxt.rx_cyc = st_r.rx_cyc + 8'h0001;
    end
    if (rx_sample) begin
      st_nxt.rx_shift = {st_r.rx_shift[10:0], rx_bit};
      st_nxt.rx_last  = rx_bit;
      if (rx_bit != st_r.rx_last) begin
        st_nxt.rx_run = 4'h0001;
      end else if (st_r.rx_run != IDLE_RUN) begin
        st_nxt.rx_run = st_r.rx_run + 4'h0001;
      end
      rx_align = (st_nxt.rx_run == IDLE_RUN) && (st_r.rx_run != IDLE_RUN);
      if (rx_align) begin
        st_nxt.rx_cnt  = WORD_LAST;
        st_nxt.rx_mode = RX_LOCK;
      end else if (st_r.rx_cnt == WORD_LAST) begin
        st_nxt.rx_cnt = 4'h0000;
        unique case (st_r.rx_mode)
          RX_HUNT: rx_done = 1'b0;
          RX_LOCK: rx_done = 1'b1;
        endcase
      end else begin
        st_nxt.rx_cnt = st_r.rx_cnt + 4'h0001;
      end
    end
    if (!rx_take_ack_n_i) begin
      st_nxt.rx_ready = 1'b0;
    end
    if (rx_done) begin
      st_nxt.rx_word  = dbc_word_t'({st_r.rx_shift[10:0], rx_bit});
      st_nxt.rx_ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tx_word_ready_o = ~st_r.hold_valid;
  assign tx_serial_o     = st_r.tx_shift.inv_bar;
  assign rx_word_ready_o = st_r.rx_ready;
  assign rx_word_o       = st_r.rx_word;

  // ****************************************
  // Checks.
  // ****************************************
  chk_word_pairs: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load |=> (st_r.tx_shift.inv_bar != st_r.tx_shift.inv)
            && (st_r.tx_shift.dc != st_r.tx_shift.dc_bar))
    else $error("Transmit word flag pairs are not complementary.");

  chk_invert_payload: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load |=>
      st_r.tx_shift.payload == ($past(enc_byte) ^ {8{st_r.tx_shift.inv}}))
    else $error("Payload does not follow the invert flag.");

  chk_idle_fill: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load && !st_r.hold_valid |=> (st_r.tx_shift.dc == st_r.tx_shift.inv)
      && (st_r.tx_shift.payload == {8{st_r.tx_shift.inv}}))
    else $error("Idle word was not sent when no data was waiting.");

  chk_sum_update: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load |=>
      st_r.run_sum == (st_r.tx_shift.inv ? $past(st_r.run_sum) - $past(enc_disp)
                                         : $past(st_r.run_sum) + $past(enc_disp)))
    else $error("Running sum updated the wrong way.");

  chk_load_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_word_ready_o && !tx_load_ack_n_i |=> !tx_word_ready_o ##0
      st_r.hold_byte == $past(tx_byte_i))
    else $error("Acknowledged load was not captured.");

  chk_bit_period: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r.tx_cyc != 8'h0000) && $past(rst_n_i) |-> $stable(tx_serial_o))
    else $error("Serial output changed inside a bit period.");

  chk_rx_filter: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(st_r.rx_lvl) && $past(rst_n_i) |-> $past(st_r.filt) == {3{st_r.rx_lvl}})
    else $error("Filtered level changed without agreeing samples.");

  chk_rx_present: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_done |=> rx_word_ready_o && (rx_word_o[0] == $past(rx_bit)))
    else $error("Completed word was not presented.");

  chk_realign: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_align |=> (st_r.rx_cnt == WORD_LAST) && (st_r.rx_mode == RX_LOCK))
    else $error("Idle run did not realign the word boundary.");

  chk_ready_return: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load && st_r.hold_valid |=> tx_word_ready_o)
    else $error("Holding word did not free up after the shifter load.");

  chk_refused_strobe: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && !tx_word_ready_o && !tx_load |=> !tx_word_ready_o && $stable(st_r.hold_byte))
    else $error("Strobe while not ready disturbed the holding word.");

  chk_data_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && tx_load && st_r.hold_valid |=>
      (st_r.tx_shift.dc ^ st_r.tx_shift.inv) == $past(st_r.hold_dc))
    else $error("Data flag of the loaded word is wrong.");

  chk_shift_order: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && (st_r.tx_cyc == BIT_LAST) && !tx_load |=> tx_serial_o == $past(st_r.tx_shift.inv))
    else $error("Serial bits left the shifter out of order.");

  chk_word_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i |-> st_r.tx_idx <= WORD_LAST)
    else $error("Bit index ran past the end of the word.");

  chk_sum_even: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i |-> !st_r.run_sum[0])
    else $error("Running sum took an odd value.");

  chk_rx_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && rx_word_ready_o && !rx_done |=> $stable(rx_word_o))
    else $error("Presented word changed without a new completion.");

  chk_rx_take: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && !rx_take_ack_n_i && !rx_done |=> !rx_word_ready_o)
    else $error("Take strobe did not clear the word ready flag.");

  chk_rx_phase: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rst_n_i && $past(rst_n_i) && $changed(st_r.rx_lvl) |-> st_r.rx_cyc == 8'h0000)
    else $error("Bit phase did not restart on a filtered edge.");

endmodule
`default_nettype wire

// ### rtl/dbc_pkg.sv
// Constants, word layout and state record of the balanced byte link codec.
package dbc_pkg;

  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_NS      = 100;
  localparam int TX_BIT_NS   = 11574;
  localparam int BIT_CYC_INT = (TX_BIT_NS / CLK_NS < 1) ? 1 : TX_BIT_NS / CLK_NS;
  localparam logic [7:0] BIT_CYC   = 8'(BIT_CYC_INT);
  localparam logic [7:0] BIT_LAST  = 8'(BIT_CYC_INT - 1);
  localparam logic [7:0] BIT_MID   = 8'(BIT_CYC_INT / 2);

  // ****************************************
  // Word format.
  // ****************************************
  localparam logic [3:0] WORD_LAST  = 4'h000b;
  localparam logic [3:0] IDLE_RUN   = 4'h000a;
  localparam logic [7:0] IDLE_BYTE  = 8'h0000;
  localparam logic       DC_CTRL    = 1'b0;
  localparam logic       DC_DATA    = 1'b1;
  localparam logic signed [5:0] SUM_RST = 6'sh00;

  typedef struct packed {
    logic       inv_bar;
    logic       inv;
    logic [7:0] payload;
    logic       dc;
    logic       dc_bar;
  } dbc_word_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_LOCK = 2'b10
  } dbc_rx_mode_t;

  typedef struct packed {
    logic [7:0]         tx_cyc;
    logic [3:0]         tx_idx;
    dbc_word_t          tx_shift;
    logic signed [5:0]  run_sum;
    logic               hold_valid;
    logic [7:0]         hold_byte;
    logic               hold_dc;
    logic [2:0]         filt;
    logic               rx_lvl;
    logic [7:0]         rx_cyc;
    logic [11:0]        rx_shift;
    logic [3:0]         rx_cnt;
    logic [3:0]         rx_run;
    logic               rx_last;
    dbc_rx_mode_t       rx_mode;
    dbc_word_t          rx_word;
    logic               rx_ready;
  } dbc_state_t;

  localparam dbc_state_t STATE_RST = '{
    tx_cyc: BIT_LAST, tx_idx: WORD_LAST, tx_shift: '0, run_sum: SUM_RST,
    hold_valid: 1'b0, hold_byte: IDLE_BYTE, hold_dc: DC_CTRL, filt: 3'h0,
    rx_lvl: 1'b0, rx_cyc: 8'h0000, rx_shift: 12'h0000, rx_cnt: 4'h0000,
    rx_run: 4'h0000, rx_last: 1'b0, rx_mode: RX_HUNT, rx_word: '0, rx_ready: 1'b0};

endpackage

// ### test/dbc_radio_model.sv
// Radio baseband model that loops the sent stream back with delay, skew and spikes.
`timescale 1ns/10ps
`default_nettype none
module dbc_radio_model (
  // Clock.
  input  wire logic clk_i,
  // Line side.
  input  wire logic tx_line_i,
  input  wire logic glitch_i,
  output logic      rx_line_o
);
  // ****************************************
  // Loopback channel.
  // ****************************************
  logic [5:0] dly_r = 6'h00;
  logic [6:0] pos_r = 7'h00;
  always @(posedge clk_i) begin
    dly_r <= {dly_r[4:0], tx_line_i};
    pos_r <= (pos_r == 7'h72) ? 7'h00 : pos_r + 7'h01;
  end
  // Highs come back three clocks short and a one-clock spike lands in every bit.
  assign rx_line_o = (dly_r[2] & dly_r[5]) ^ (glitch_i & (pos_r == 7'h14));
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking testbench of the balanced byte link codec.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dbc_pkg::*;
  // ****************************************
  // Signals and checks.
  // ****************************************
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  tx_byte_i = 8'h00;
  logic        tx_dc_i = 1'b0;
  logic        tx_load_ack_n_i = 1'b1;
  logic        rx_take_ack_n_i = 1'b1;
  logic        glitch = 1'b0;
  logic        tx_word_ready_o, tx_serial_o, rx_serial_i, rx_word_ready_o;
  dbc_word_t   rx_word_o;
  dbc_word_t   ew [10];
  dbc_word_t   rxq [$];
  logic [11:0] got [16];
  logic [11:0] sh = 12'h000;
  logic [7:0]  bt [5] = '{8'hff, 8'hff, 8'h00, 8'h0f, 8'h05};
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cyc = 0, cnt = 0, nb = 0, nw = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  dbc_codec dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tx_byte_i(tx_byte_i),
    .tx_dc_i(tx_dc_i), .tx_load_ack_n_i(tx_load_ack_n_i), .tx_word_ready_o(tx_word_ready_o),
    .tx_serial_o(tx_serial_o), .rx_serial_i(rx_serial_i), .rx_word_ready_o(rx_word_ready_o),
    .rx_take_ack_n_i(rx_take_ack_n_i), .rx_word_o(rx_word_o));
  dbc_radio_model radio (.clk_i(ref_clk_i), .tx_line_i(tx_serial_o), .glitch_i(glitch),
    .rx_line_o(rx_serial_i));
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Timeout, mid-bit capture of the line and the receiving host.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
    cnt <= (rst_n_i !== 1'b1 || cnt == 114) ? 0 : cnt + 1;
    if (cnt == 60 && nw < 16) begin
      sh = {sh[10:0], tx_serial_o};
      nb = (nb == 11) ? 0 : nb + 1;
      if (nb == 0) begin
        got[nw] = sh;
        nw++;
      end
    end
    if (rx_word_ready_o === 1'b1 && rx_take_ack_n_i === 1'b1) begin
      rxq.push_back(rx_word_o);
      rx_take_ack_n_i <= 1'b0;
    end else begin
      rx_take_ack_n_i <= 1'b1;
    end
  end
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic load(input logic [7:0] b, input logic d);
    int n;
    n = 0;
    while (tx_word_ready_o !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    tx_byte_i <= b;
    tx_dc_i <= d;
    tx_load_ack_n_i <= 1'b0;
    @(posedge ref_clk_i);
    tx_load_ack_n_i <= 1'b1;
    @(posedge ref_clk_i);
    check({11'h000, tx_word_ready_o}, 12'h000);
    tx_byte_i <= 8'haa;
    tx_load_ack_n_i <= 1'b0;
    @(posedge ref_clk_i);
    tx_load_ack_n_i <= 1'b1;
    while (tx_word_ready_o !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask
  task automatic test_reset();
    check({tx_word_ready_o, rx_word_ready_o, tx_serial_o}, 12'h004);
    check(rx_word_o, 12'h000);
    $display("test reset done");
  endtask
  task automatic test_tx();
    for (int i = 0; i < 5; i++) begin
      load(bt[i], i < 4); // Data goes with flag one, control with zero.
    end
    $display("test tx load done");
  endtask
  task automatic test_wire();
    int s, k, n;
    logic [7:0] b;
    logic d, v;
    s = 0;
    for (int i = 0; i < 10; i++) begin
      b = (i >= 1 && i <= 5) ? bt[i - 1] : 8'h00;
      d = (i >= 1 && i <= 4);
      k = 2 * $countones(b) - 8;
      v = ((k < 0) == (s < 0));
      s = v ? s - k : s + k;
      ew[i] = '{~v, v, b ^ {8{v}}, d ^ v, ~(d ^ v)};
    end
    for (n = 0; nw < 10 && n < 9000; n++) @(posedge ref_clk_i);
    for (int i = 0; i < 10; i++) begin
      check(got[i], ew[i]);
    end
    $display("test wire done");
  endtask
  task automatic test_rx();
    int n, gap;
    logic [7:0] b;
    logic [8:0] e;
    logic d;
    dbc_word_t w;
    logic [7:0] dq [$];
    for (n = 0; rxq.size() < 9 && n < 3000; n++) @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++) begin
      check(rxq[i], ew[i]);
    end
    // Host decode drops bad pairs, undoes inversion, queues data and watches idle spacing.
    gap = 0;
    for (int i = 0; i < 9; i++) begin
      w = rxq[i];
      e = {(i >= 1 && i <= 4), (i >= 1 && i <= 5) ? bt[i - 1] : 8'h00};
      check({10'h000, w.inv_bar ^ w.inv, w.dc ^ w.dc_bar}, 12'h003);
      if ((w.inv_bar ^ w.inv) && (w.dc ^ w.dc_bar)) begin
        b = w.payload ^ {8{w.inv}};
        d = w.dc ^ w.inv;
        check({3'h0, d, b}, {3'h0, e});
        if (d) begin
          dq.push_back(b);
        end
        gap = (!d && b == 8'h00) ? 0 : gap + 1;
        check({11'h000, gap > 24}, 12'h000);
      end
    end
    check(12'(dq.size()), 12'h004);
    for (int i = 0; i < 4; i++) begin
      check({4'h0, dq[i]}, {4'h0, bt[i]});
    end
    $display("test rx done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    test_reset();
    rst_n_i <= 1'b1;
    glitch <= 1'b1;
    test_tx();
    test_wire();
    test_rx();
    conclude();
  end
endmodule
`default_nettype wire
